// ==== include/temp_regs_pkg.sv ====
// Constants, types and register map of the temperature monitor register file
// Function
// [R01] An eight-bit index register selects the register answering the next access.
// [R02] Every write transaction reloads the index register from its first data byte.
// [R03] Master writes the index before reading the wanted register.
// [R04] The index register is zero after reset.
// [R05] Local reading: high byte at index 00, low nibble in upper nibble of 15.
// [R06] Remote reading: high byte at index 01, low nibble in upper nibble of 10.
// [R07] Low four reading bits are the fraction, high byte the integer part.
// [R08] Result registers are read-only and refresh at each finished measurement.
// [R09] Reading a high result byte freezes that channel's low byte until read.
// [R10] Reading a low result byte first freezes that channel's high byte until read.
// [R11] Reading any other register releases the byte pairing lock.
// [R12] Master reads high byte first, then low byte next, or skips low byte.
// [R13] All temperature result registers read zero after reset.
// [R14] Any write to index 0F starts one conversion; it has no readable contents.
// [R15] Local upper bound reads at 05, writes at 0B.
// [R16] Local lower bound reads at 06, writes at 0C, resets to zero.
// [R17] Remote upper bound: high byte read 07 write 0D, fraction nibble at 13.
// [R18] Remote lower bound: high byte read 08 write 0E, fraction nibble at 14.
// [R19] Remote offset: high byte at 11, fraction nibble at 12, same read/write index.
// [R20] Shutdown limits at 19 and 20, each resetting to 6E.
// [R21] First written byte loads the index; later bytes go to the selected register.
// [R22] Reads leave the index unchanged.
// [R23] Fixed map bits read as their constants; writes to them are ignored.
package temp_regs_pkg;
  localparam logic [7:0] RD_LOCAL_MSB    = 8'h00;
  localparam logic [7:0] RD_REMOTE_MSB   = 8'h01;
  localparam logic [7:0] RD_STATUS       = 8'h02;
  localparam logic [7:0] RD_CONFIG       = 8'h03;
  localparam logic [7:0] RD_INTERVAL     = 8'h04;
  localparam logic [7:0] RD_LOC_UPPER    = 8'h05;
  localparam logic [7:0] RD_LOC_LOWER    = 8'h06;
  localparam logic [7:0] RD_REM_UPPER_M  = 8'h07;
  localparam logic [7:0] RD_REM_LOWER_M  = 8'h08;
  localparam logic [7:0] WR_CONFIG       = 8'h09;
  localparam logic [7:0] WR_INTERVAL     = 8'h0A;
  localparam logic [7:0] WR_LOC_UPPER    = 8'h0B;
  localparam logic [7:0] WR_LOC_LOWER    = 8'h0C;
  localparam logic [7:0] WR_REM_UPPER_M  = 8'h0D;
  localparam logic [7:0] WR_REM_LOWER_M  = 8'h0E;
  localparam logic [7:0] WR_ONE_SHOT     = 8'h0F;
  localparam logic [7:0] RD_REMOTE_LSB   = 8'h10;
  localparam logic [7:0] RW_OFFSET_M     = 8'h11;
  localparam logic [7:0] RW_OFFSET_L     = 8'h12;
  localparam logic [7:0] RW_REM_UPPER_L  = 8'h13;
  localparam logic [7:0] RW_REM_LOWER_L  = 8'h14;
  localparam logic [7:0] RD_LOCAL_LSB    = 8'h15;
  localparam logic [7:0] RW_REM_SHUTDOWN = 8'h19;
  localparam logic [7:0] RW_LOC_SHUTDOWN = 8'h20;
  localparam logic [7:0] RW_MARGIN       = 8'h21;
  localparam logic [7:0] RW_REPEAT       = 8'h22;
  localparam logic [7:0] RW_IDEALITY     = 8'h23;
  localparam logic [7:0] RW_SMOOTHING    = 8'h24;
  localparam logic [7:0] RD_MAKER        = 8'hFE;

  localparam logic [7:0] INDEX_RST       = 8'h00;
  localparam logic [7:0] ZERO_RST        = 8'h00;
  localparam logic [7:0] INTERVAL_RST    = 8'h08;
  localparam logic [7:0] UPPER_RST       = 8'h55;
  localparam logic [7:0] SHUTDOWN_RST    = 8'h6E;
  localparam logic [7:0] MARGIN_RST      = 8'h0A;
  localparam logic [7:0] REPEAT_RST      = 8'h01;
  // Arbitrary neutral identity value
  localparam logic [7:0] MAKER_CODE      = 8'hA5;

  // Writable bit masks; other bits are fixed
  localparam logic [7:0] CONFIG_MASK     = 8'hE4;
  localparam logic [7:0] INTERVAL_MASK   = 8'h0F;
  localparam logic [7:0] NIBBLE_MASK     = 8'hF0;
  localparam logic [7:0] REPEAT_MASK     = 8'h8E;
  localparam logic [7:0] REPEAT_FIXED    = 8'h01;
  localparam logic [7:0] SMOOTHING_MASK  = 8'h03;
  localparam logic [3:0] NIBBLE_PAD      = 4'h0;

  // Result of one conversion, 12 bits per channel
  typedef struct packed {
    logic [11:0] local_reading;
    logic [11:0] remote_reading;
  } reading_pair_t;

  // Register access from the serial engine
  typedef struct packed {
    logic       wr_byte;
    logic       first_byte;
    logic       rd_byte;
    logic [7:0] data;
  } bus_access_t;

  typedef enum logic [1:0] {
    LOCK_NONE = 2'b00,
    LOCK_MSB  = 2'b01,
    LOCK_LSB  = 2'b11
  } lock_state_t;
endpackage

// ==== rtl/temp_monitor_register_file.sv ====
// Register file of the local and remote temperature monitor
`timescale 1ns/1ps
module temp_monitor_register_file
  import temp_regs_pkg::*;
(
  input  wire logic          clk_in,
  input  wire logic          rst_in,
  input  wire logic          clk_en_in,
  input  wire bus_access_t   access_in,
  input  wire logic          conv_done_in,
  input  wire reading_pair_t conv_result_in,
  input  wire logic [7:0]    alarm_flags_in,
  output logic [7:0]         rd_data_out,
  output logic [7:0]         index_out,
  output logic               one_shot_out,
  output logic [7:0]         setup_control_out,
  output logic [7:0]         sample_interval_out,
  output logic [7:0]         local_upper_bound_out,
  output logic [7:0]         local_lower_bound_out,
  output logic [11:0]        remote_upper_bound_out,
  output logic [11:0]        remote_lower_bound_out,
  output logic [11:0]        remote_offset_out,
  output logic [7:0]         remote_shutdown_out,
  output logic [7:0]         local_shutdown_out,
  output logic [7:0]         return_margin_out,
  output logic [7:0]         repeat_alarm_out,
  output logic [7:0]         ideality_out,
  output logic [7:0]         smoothing_out,
  output reading_pair_t      reading_out
);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic        wr_index;
  logic        wr_data;
  logic        rd_any;
  logic [7:0]  wd;
  lock_state_t local_lock_ff;
  lock_state_t remote_lock_ff;
  lock_state_t nxt_local_lock;
  lock_state_t nxt_remote_lock;
  logic [7:0]  nxt_rd_data;

  assign wr_index = clk_en_in & access_in.wr_byte & access_in.first_byte;
  assign wr_data  = clk_en_in & access_in.wr_byte & ~access_in.first_byte;
  assign rd_any   = clk_en_in & access_in.rd_byte;
  assign wd       = access_in.data;

  // ----------------------------------------------------------------
  // Index register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      index_out <= INDEX_RST; // [R04]
    end else if (wr_index) begin
      index_out <= wd; // [R01] [R02] [R21] [R22]
    end
  end

  // ----------------------------------------------------------------
  // One-shot trigger
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      one_shot_out <= 1'b0;
    end else if (clk_en_in) begin
      one_shot_out <= wr_data && (index_out == WR_ONE_SHOT); // [R14]
    end
  end

  // ----------------------------------------------------------------
  // Writable registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      setup_control_out      <= ZERO_RST;
      sample_interval_out    <= INTERVAL_RST;
      local_upper_bound_out  <= UPPER_RST;
      local_lower_bound_out  <= ZERO_RST; // [R16]
      remote_upper_bound_out <= {UPPER_RST, NIBBLE_PAD};
      remote_lower_bound_out <= {ZERO_RST, NIBBLE_PAD};
      remote_offset_out      <= {ZERO_RST, NIBBLE_PAD};
      remote_shutdown_out    <= SHUTDOWN_RST; // [R20]
      local_shutdown_out     <= SHUTDOWN_RST; // [R20]
      return_margin_out      <= MARGIN_RST;
      repeat_alarm_out       <= REPEAT_RST;
      ideality_out           <= ZERO_RST;
      smoothing_out          <= ZERO_RST;
    end else if (wr_data) begin
      case (index_out)
        WR_CONFIG:       setup_control_out <= wd & CONFIG_MASK; // [R23]
        WR_INTERVAL:     sample_interval_out <= wd & INTERVAL_MASK; // [R23]
        WR_LOC_UPPER:    local_upper_bound_out <= wd; // [R15]
        WR_LOC_LOWER:    local_lower_bound_out <= wd; // [R16]
        WR_REM_UPPER_M:  remote_upper_bound_out[11:4] <= wd; // [R17]
        WR_REM_LOWER_M:  remote_lower_bound_out[11:4] <= wd; // [R18]
        RW_REM_UPPER_L:  remote_upper_bound_out[3:0] <= wd[7:4]; // [R17]
        RW_REM_LOWER_L:  remote_lower_bound_out[3:0] <= wd[7:4]; // [R18]
        RW_OFFSET_M:     remote_offset_out[11:4] <= wd; // [R19]
        RW_OFFSET_L:     remote_offset_out[3:0] <= wd[7:4]; // [R19]
        RW_REM_SHUTDOWN: remote_shutdown_out <= wd; // [R20]
        RW_LOC_SHUTDOWN: local_shutdown_out <= wd; // [R20]
        RW_MARGIN:       return_margin_out <= wd;
        RW_REPEAT:       repeat_alarm_out <= (wd & REPEAT_MASK) | REPEAT_FIXED; // [R23]
        RW_IDEALITY:     ideality_out <= wd;
        RW_SMOOTHING:    smoothing_out <= wd & SMOOTHING_MASK; // [R23]
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Byte-pairing locks
  // ----------------------------------------------------------------
  function automatic lock_state_t next_lock(input lock_state_t cur,
                                            input logic [7:0] idx,
                                            input logic [7:0] msb_idx,
                                            input logic [7:0] lsb_idx);
    lock_state_t res;
    res = cur;
    if (idx == msb_idx) begin
      res = (cur == LOCK_LSB) ? LOCK_NONE : LOCK_MSB; // [R09]
    end else if (idx == lsb_idx) begin
      res = (cur == LOCK_MSB) ? LOCK_NONE : LOCK_LSB; // [R10]
    end else begin
      res = LOCK_NONE; // [R11]
    end
    return res;
  endfunction

  // A read takes its lock in the same cycle as a finished conversion,
  // so the byte just sent and its partner stay from one conversion
  always_comb begin
    nxt_local_lock  = local_lock_ff;
    nxt_remote_lock = remote_lock_ff;
    if (rd_any) begin
      nxt_local_lock  = next_lock(local_lock_ff, index_out, RD_LOCAL_MSB, RD_LOCAL_LSB);
      nxt_remote_lock = next_lock(remote_lock_ff, index_out, RD_REMOTE_MSB, RD_REMOTE_LSB);
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      local_lock_ff  <= LOCK_NONE;
      remote_lock_ff <= LOCK_NONE;
    end else if (clk_en_in) begin
      local_lock_ff  <= nxt_local_lock; // [R09] [R10] [R11]
      remote_lock_ff <= nxt_remote_lock; // [R09] [R10] [R11]
    end
  end

  // ----------------------------------------------------------------
  // Result registers, read-only, fraction in low nibble
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      reading_out <= '0; // [R13]
    end else if (clk_en_in && conv_done_in) begin
      if (nxt_local_lock != LOCK_LSB) begin
        reading_out.local_reading[11:4] <= conv_result_in.local_reading[11:4]; // [R05] [R08]
      end
      if (nxt_local_lock != LOCK_MSB) begin
        reading_out.local_reading[3:0] <= conv_result_in.local_reading[3:0]; // [R07] [R09]
      end
      if (nxt_remote_lock != LOCK_LSB) begin
        reading_out.remote_reading[11:4] <= conv_result_in.remote_reading[11:4]; // [R06] [R10]
      end
      if (nxt_remote_lock != LOCK_MSB) begin
        reading_out.remote_reading[3:0] <= conv_result_in.remote_reading[3:0]; // [R07] [R08]
      end
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    case (index_out)
      RD_LOCAL_MSB:    nxt_rd_data = reading_out.local_reading[11:4]; // [R05]
      RD_REMOTE_MSB:   nxt_rd_data = reading_out.remote_reading[11:4]; // [R06]
      RD_STATUS:       nxt_rd_data = alarm_flags_in;
      RD_CONFIG:       nxt_rd_data = setup_control_out;
      RD_INTERVAL:     nxt_rd_data = sample_interval_out;
      RD_LOC_UPPER:    nxt_rd_data = local_upper_bound_out; // [R15]
      RD_LOC_LOWER:    nxt_rd_data = local_lower_bound_out; // [R16]
      RD_REM_UPPER_M:  nxt_rd_data = remote_upper_bound_out[11:4]; // [R17]
      RD_REM_LOWER_M:  nxt_rd_data = remote_lower_bound_out[11:4]; // [R18]
      RD_REMOTE_LSB:   nxt_rd_data = {reading_out.remote_reading[3:0], NIBBLE_PAD}; // [R06]
      RW_OFFSET_M:     nxt_rd_data = remote_offset_out[11:4]; // [R19]
      RW_OFFSET_L:     nxt_rd_data = {remote_offset_out[3:0], NIBBLE_PAD}; // [R19]
      RW_REM_UPPER_L:  nxt_rd_data = {remote_upper_bound_out[3:0], NIBBLE_PAD}; // [R17]
      RW_REM_LOWER_L:  nxt_rd_data = {remote_lower_bound_out[3:0], NIBBLE_PAD}; // [R18]
      RD_LOCAL_LSB:    nxt_rd_data = {reading_out.local_reading[3:0], NIBBLE_PAD}; // [R05]
      RW_REM_SHUTDOWN: nxt_rd_data = remote_shutdown_out;
      RW_LOC_SHUTDOWN: nxt_rd_data = local_shutdown_out;
      RW_MARGIN:       nxt_rd_data = return_margin_out;
      RW_REPEAT:       nxt_rd_data = repeat_alarm_out;
      RW_IDEALITY:     nxt_rd_data = ideality_out;
      RW_SMOOTHING:    nxt_rd_data = smoothing_out;
      RD_MAKER:        nxt_rd_data = MAKER_CODE;
      default:         nxt_rd_data = ZERO_RST; // [R14]
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_data_out <= ZERO_RST;
    end else if (clk_en_in) begin
      rd_data_out <= nxt_rd_data;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  // Index register and trigger
  index_load_a: assert property ( // [R02]
    wr_index
    |=> index_out == $past(wd))
    else $error("index not loaded by first write byte");

  index_hold_a: assert property ( // [R22]
    !wr_index
    |=> $stable(index_out))
    else $error("index changed without write");

  oneshot_pulse_a: assert property ( // [R14]
    wr_data && index_out == WR_ONE_SHOT
    |=> one_shot_out ##1 (!one_shot_out || $past(wr_data) || !$past(clk_en_in)))
    else $error("one-shot trigger not a pulse");

  no_shot_a: assert property ( // [R14]
    clk_en_in && !(wr_data && index_out == WR_ONE_SHOT)
    |=> !one_shot_out)
    else $error("one-shot without trigger write");

  trigger_read_a: assert property ( // [R14]
    clk_en_in && index_out == WR_ONE_SHOT
    |=> rd_data_out == ZERO_RST)
    else $error("trigger location reads nonzero");

  enable_freeze_a: assert property (
    !clk_en_in
    |=> $stable(index_out) && $stable(one_shot_out)
        && $stable(rd_data_out) && $stable(reading_out))
    else $error("state moved with enable low");

  // Byte-pairing locks
  msb_lock_a: assert property ( // [R09]
    rd_any && index_out == RD_LOCAL_MSB && local_lock_ff == LOCK_NONE
    |=> local_lock_ff == LOCK_MSB)
    else $error("local msb read did not lock low byte");

  lsb_lock_a: assert property ( // [R10]
    rd_any && index_out == RD_REMOTE_LSB && remote_lock_ff == LOCK_NONE
    |=> remote_lock_ff == LOCK_LSB)
    else $error("remote lsb read did not lock high byte");

  pair_done_a: assert property ( // [R09]
    rd_any && index_out == RD_LOCAL_LSB && local_lock_ff == LOCK_MSB
    |=> local_lock_ff == LOCK_NONE)
    else $error("low byte read did not end pair");

  frozen_lsb_a: assert property ( // [R09]
    nxt_local_lock == LOCK_MSB
    |=> reading_out.local_reading[3:0] == $past(reading_out.local_reading[3:0]))
    else $error("locked low byte changed");

  frozen_msb_a: assert property ( // [R10]
    nxt_remote_lock == LOCK_LSB
    |=> reading_out.remote_reading[11:4] == $past(reading_out.remote_reading[11:4]))
    else $error("locked high byte changed");

  lock_release_a: assert property ( // [R11]
    rd_any && index_out != RD_REMOTE_MSB && index_out != RD_REMOTE_LSB
    |=> remote_lock_ff == LOCK_NONE)
    else $error("remote lock not released");

  local_release_a: assert property ( // [R11]
    rd_any && index_out != RD_LOCAL_MSB && index_out != RD_LOCAL_LSB
    |=> local_lock_ff == LOCK_NONE)
    else $error("local lock not released");

  // Results and read data
  result_update_a: assert property ( // [R08]
    clk_en_in && conv_done_in && nxt_local_lock == LOCK_NONE
    |=> reading_out.local_reading == $past(conv_result_in.local_reading))
    else $error("local result not refreshed");

  remote_update_a: assert property ( // [R08]
    clk_en_in && conv_done_in && nxt_remote_lock == LOCK_NONE
    |=> reading_out.remote_reading == $past(conv_result_in.remote_reading))
    else $error("remote result not refreshed");

  result_hold_a: assert property ( // [R08]
    !(clk_en_in && conv_done_in)
    |=> $stable(reading_out))
    else $error("result changed without conversion");

  local_msb_read_a: assert property ( // [R05]
    clk_en_in && index_out == RD_LOCAL_MSB
    |=> rd_data_out == $past(reading_out.local_reading[11:4]))
    else $error("local high byte read wrong");

  local_lsb_read_a: assert property ( // [R05] [R07]
    clk_en_in && index_out == RD_LOCAL_LSB
    |=> rd_data_out == {$past(reading_out.local_reading[3:0]), NIBBLE_PAD})
    else $error("local low byte read wrong");

  remote_msb_read_a: assert property ( // [R06]
    clk_en_in && index_out == RD_REMOTE_MSB
    |=> rd_data_out == $past(reading_out.remote_reading[11:4]))
    else $error("remote high byte read wrong");

  remote_lsb_read_a: assert property ( // [R06] [R07]
    clk_en_in && index_out == RD_REMOTE_LSB
    |=> rd_data_out == {$past(reading_out.remote_reading[3:0]), NIBBLE_PAD})
    else $error("remote low byte read wrong");

  upper_read_a: assert property ( // [R17]
    clk_en_in && index_out == RD_REM_UPPER_M
    |=> rd_data_out == $past(remote_upper_bound_out[11:4]))
    else $error("remote upper bound read wrong");

  // Writes and fixed bits
  upper_write_a: assert property ( // [R15]
    wr_data && index_out == WR_LOC_UPPER
    |=> local_upper_bound_out == $past(wd))
    else $error("local upper bound not written");

  lower_write_a: assert property ( // [R16]
    wr_data && index_out == WR_LOC_LOWER
    |=> local_lower_bound_out == $past(wd))
    else $error("local lower bound not written");

  bound_nibble_a: assert property ( // [R18]
    wr_data && index_out == RW_REM_LOWER_L
    |=> remote_lower_bound_out[3:0] == $past(wd[7:4]))
    else $error("lower bound nibble not written");

  offset_nibble_a: assert property ( // [R19]
    wr_data && index_out == RW_OFFSET_L
    |=> remote_offset_out[3:0] == $past(wd[7:4]))
    else $error("offset nibble not written");

  shutdown_write_a: assert property ( // [R20]
    wr_data && index_out == RW_REM_SHUTDOWN
    |=> remote_shutdown_out == $past(wd))
    else $error("shutdown limit not written");

  fixed_bits_a: assert property ( // [R23]
    repeat_alarm_out[0]
    && (sample_interval_out & ~INTERVAL_MASK) == ZERO_RST)
    else $error("fixed bits corrupted");

  config_bits_a: assert property ( // [R23]
    (setup_control_out & ~CONFIG_MASK) == ZERO_RST
    && (smoothing_out & ~SMOOTHING_MASK) == ZERO_RST)
    else $error("fixed setup bits corrupted");

  // Main scenarios
  pair_read_c: cover property (
    rd_any && index_out == RD_LOCAL_MSB ##[1:20] rd_any && index_out == RD_LOCAL_LSB);

  oneshot_c: cover property (one_shot_out);

  locked_update_c: cover property (remote_lock_ff == LOCK_LSB && conv_done_in);

  lsb_first_c: cover property (
    rd_any && index_out == RD_REMOTE_LSB && remote_lock_ff == LOCK_NONE);

  frozen_write_c: cover property (!clk_en_in && access_in.wr_byte);

endmodule

// ==== bench/bus_master_model.sv ====
// Serial bus master model that issues index writes, data writes and reads
`timescale 1ns/1ps
module bus_master_model
  import temp_regs_pkg::*;
(
  input  wire logic   clk_in,
  output bus_access_t access_out
);
  initial access_out = '0;

  // --------------------------------------------------------------------
  // Access pulses
  // --------------------------------------------------------------------
  // One pulse, then the data lines carry the inverse of the last byte
  task automatic pulse(input logic wr, first, rd, input logic [7:0] d);
    @(posedge clk_in);
    #1;
    access_out = {wr, first, rd, d};
    @(posedge clk_in);
    #1;
    access_out = {3'b000, ~d};
    @(posedge clk_in);
    #1;
  endtask

  task automatic set_index(input logic [7:0] idx);
    pulse(1'b1, 1'b1, 1'b0, idx);
  endtask

  task automatic write_reg(input logic [7:0] idx, d);
    set_index(idx);
    pulse(1'b1, 1'b0, 1'b0, d);
  endtask

  task automatic read_at(input logic [7:0] idx);
    set_index(idx);
    pulse(1'b0, 1'b0, 1'b1, 8'h00);
  endtask

  task automatic read_again();
    pulse(1'b0, 1'b0, 1'b1, 8'h00);
  endtask
endmodule

// ==== bench/temp_monitor_register_file_tb.sv ====
// Self-checking bench for the temperature monitor register file
`timescale 1ns/1ps
module temp_monitor_register_file_tb
  import temp_regs_pkg::*;
;
  // --------------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------------
  logic          clk_in = 1'b0;
  logic          rst_in = 1'b1;
  logic          clk_en_in = 1'b1;
  logic          conv_done_in = 1'b0;
  reading_pair_t conv_result_in = '0;
  logic [7:0]    alarm_flags_in = 8'h00;
  bus_access_t   access_in;
  logic [7:0]    rd_data_out;
  logic [7:0]    index_out;
  logic          one_shot_out;
  logic [11:0]   remote_offset_out;
  logic [7:0]    exp_q[$];
  int            num_errors = 0;
  int            total_checks = 0;
  int            shots = 0;

  localparam logic [15:0] RST_TAB [23] = '{16'h0000, 16'h0100, 16'h0300, 16'h0408,
    16'h0555, 16'h0600, 16'h0755, 16'h0800, 16'h0F00, 16'h1000, 16'h1100, 16'h1200,
    16'h1300, 16'h1400, 16'h1500, 16'h196E, 16'h206E, 16'h210A, 16'h2201, 16'h2300,
    16'h2400, 16'h3000, {RD_MAKER, MAKER_CODE}};
  // Write index, read index, writable mask, fixed ones
  localparam logic [31:0] WR_TAB [16] = '{32'h0903_E400, 32'h0A04_0F00, 32'h0B05_FF00,
    32'h0C06_FF00, 32'h0D07_FF00, 32'h0E08_FF00, 32'h1111_FF00, 32'h1212_F000,
    32'h1313_F000, 32'h1414_F000, 32'h1919_FF00, 32'h2020_FF00, 32'h2121_FF00,
    32'h2222_8E01, 32'h2323_FF00, 32'h2424_0300};

  always #12.5 clk_in = ~clk_in;

  bus_master_model bus_master_model_inst (.clk_in(clk_in), .access_out(access_in));

  temp_monitor_register_file temp_monitor_register_file_inst (
    .clk_in(clk_in), .rst_in(rst_in), .clk_en_in(clk_en_in), .access_in(access_in),
    .conv_done_in(conv_done_in), .conv_result_in(conv_result_in),
    .alarm_flags_in(alarm_flags_in), .rd_data_out(rd_data_out), .index_out(index_out),
    .one_shot_out(one_shot_out), .setup_control_out(), .sample_interval_out(),
    .local_upper_bound_out(), .local_lower_bound_out(), .remote_upper_bound_out(),
    .remote_lower_bound_out(), .remote_offset_out(remote_offset_out),
    .remote_shutdown_out(), .local_shutdown_out(), .return_margin_out(),
    .repeat_alarm_out(), .ideality_out(), .smoothing_out(), .reading_out());

  // --------------------------------------------------------------------
  // Checking
  // --------------------------------------------------------------------
  task automatic check(input logic [7:0] got, exp, input string what);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Each read pulse takes the oldest expected byte off the queue
  always @(posedge clk_in) begin
    if (access_in.rd_byte === 1'b1 && clk_en_in === 1'b1) begin
      if (exp_q.size() == 0) check(rd_data_out, 8'hxx, "unexpected read");
      else check(rd_data_out, exp_q.pop_front(), "read data");
    end
    if (one_shot_out === 1'b1) shots++;
  end

  task automatic expect_at(input logic [7:0] idx, exp);
    exp_q.push_back(exp);
    bus_master_model_inst.read_at(idx);
  endtask

  task automatic convert(input logic [11:0] loc, rem);
    @(posedge clk_in);
    #1;
    conv_done_in = 1'b1;
    conv_result_in = {loc, rem};
    @(posedge clk_in);
    #1;
    conv_done_in = 1'b0;
    @(posedge clk_in);
    #1;
  endtask

  // --------------------------------------------------------------------
  // Tests
  // --------------------------------------------------------------------
  initial begin
    logic [7:0]  d;
    logic [11:0] la, ra, lb, rb, lc, rc, ld;
    int          s0;
    void'($urandom(32'hCC2A_8A53));
    repeat (2) @(posedge clk_in);
    #1;
    rst_in = 1'b0;
    check(index_out, INDEX_RST, "index after reset");
    exp_q.push_back(8'h00);
    bus_master_model_inst.read_again();
    foreach (RST_TAB[i]) expect_at(RST_TAB[i][15:8], RST_TAB[i][7:0]);
    foreach (WR_TAB[i]) begin
      d = 8'($urandom);
      bus_master_model_inst.write_reg(WR_TAB[i][31:24], d);
      expect_at(WR_TAB[i][23:16], (d & WR_TAB[i][15:8]) | WR_TAB[i][7:0]);
    end
    bus_master_model_inst.write_reg(RW_OFFSET_M, 8'h9C);
    bus_master_model_inst.write_reg(RW_OFFSET_L, 8'h5F);
    check(remote_offset_out[11:4], 8'h9C, "offset high");
    check({remote_offset_out[3:0], 4'h0}, 8'h50, "offset low");
    bus_master_model_inst.write_reg(RD_LOCAL_MSB, 8'hFF);
    expect_at(RD_LOCAL_MSB, 8'h00);
    alarm_flags_in = 8'($urandom);
    expect_at(RD_STATUS, alarm_flags_in);
    s0 = shots;
    bus_master_model_inst.write_reg(WR_ONE_SHOT, 8'($urandom));
    check(index_out, WR_ONE_SHOT, "index after write");
    check(8'(shots - s0), 8'h01, "one-shot pulses");
    {la, ra, lb, rb, lc, rc} = 72'({$urandom, $urandom, $urandom});
    ld = 12'($urandom);
    convert(la, ra);
    expect_at(RD_LOCAL_MSB, la[11:4]);
    expect_at(RD_LOCAL_LSB, {la[3:0], 4'h0});
    expect_at(RD_REMOTE_MSB, ra[11:4]);
    expect_at(RD_REMOTE_LSB, {ra[3:0], 4'h0});
    // Pair lock: high byte first, then low byte first, then released
    expect_at(RD_LOCAL_MSB, la[11:4]);
    convert(lb, rb);
    expect_at(RD_LOCAL_LSB, {la[3:0], 4'h0});
    expect_at(RD_REMOTE_LSB, {rb[3:0], 4'h0});
    convert(lc, rc);
    expect_at(RD_REMOTE_MSB, rb[11:4]);
    expect_at(RD_LOCAL_MSB, lc[11:4]);
    expect_at(RD_STATUS, alarm_flags_in);
    convert(ld, rc);
    expect_at(RD_LOCAL_LSB, {ld[3:0], 4'h0});
    bus_master_model_inst.write_reg(WR_LOC_UPPER, 8'h3C);
    clk_en_in = 1'b0;
    bus_master_model_inst.write_reg(WR_LOC_UPPER, 8'hC3);
    clk_en_in = 1'b1;
    expect_at(RD_LOC_UPPER, 8'h3C);
    rst_in = 1'b1;
    repeat (2) @(posedge clk_in);
    #1;
    rst_in = 1'b0;
    check(index_out, INDEX_RST, "index after second reset");
    expect_at(RD_LOC_UPPER, UPPER_RST);
    expect_at(RD_LOCAL_LSB, 8'h00);
    check(8'(exp_q.size()), 8'h00, "reads left over");
    close_out();
  end

  initial begin
    #200_000;
    num_errors++;
    close_out();
  end
endmodule
